/* File: design/sci_apb_bridge.sv */
`timescale 1ns/1ps
`default_nettype none
module sci_apb_bridge (
   input wire logic ref_clk,
   input wire logic resetn,
   sci_apb_if.bridge bus,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [5:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [15:0] rsp_rdata
);
   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SETUP = 2'b01,
      ST_ENABLE = 2'b10
   } state_t;
   state_t st_q, st_d;
   logic sel_q, sel_d, en_q, en_d, wr_q, wr_d, rv_q, rv_d;
   logic [5:0] addr_q, addr_d;
   logic [15:0] wd_q, wd_d, rd_q, rd_d;
   always_comb begin
      st_d = st_q;
      sel_d = sel_q;
      en_d = 1'b0;
      wr_d = wr_q;
      addr_d = addr_q;
      wd_d = wd_q;
      rd_d = rd_q;
      rv_d = 1'b0;
      case (st_q)
         ST_IDLE: begin
            if (req_valid) begin
               st_d = ST_SETUP;
               sel_d = 1'b1;
               wr_d = req_write;
               addr_d = req_addr;
               wd_d = req_wdata;
            end
         end
         ST_SETUP: begin
            st_d = ST_ENABLE;
            en_d = 1'b1; // [RULE4]
         end
         ST_ENABLE: begin
            st_d = ST_IDLE;
            sel_d = 1'b0;
            rv_d = 1'b1;
            rd_d = wr_q ? rd_q : bus.prdata;
         end
         default: st_d = ST_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         st_q <= ST_IDLE;
         sel_q <= 1'b0;
         en_q <= 1'b0;
         wr_q <= 1'b0;
         addr_q <= 6'h00;
         wd_q <= 16'h0000;
         rd_q <= 16'h0000;
         rv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sel_q <= sel_d;
         en_q <= en_d;
         wr_q <= wr_d;
         addr_q <= addr_d;
         wd_q <= wd_d;
         rd_q <= rd_d;
         rv_q <= rv_d;
      end
   end
   assign bus.psel = sel_q;
   assign bus.penable = en_q;
   assign bus.pwrite = wr_q;
   assign bus.paddr = addr_q;
   assign bus.pwdata = wd_q;
   assign req_ready = (st_q == ST_IDLE);
   assign rsp_valid = rv_q;
   assign rsp_rdata = rd_q;
endmodule : sci_apb_bridge
`default_nettype wire

/* File: design/sci_apb_port.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RULE1] Slave decodes only word address bits 7:2
// [RULE2] Bus logic reset by active-low bus reset
// [RULE3] Bus transfers timed by the bus clock
// [RULE4] Bridge holds enable high exactly one cycle
// [RULE5] Select high requests transfer; low ignored
// [RULE6] Write high writes, low reads
// [RULE7] Separate one-way 16-bit read and write paths
// [RULE8] Card timing on reference clock, own reset
// [RULE9] Reference reset asserted async, released synchronously; code applies ref_domain_reset_n synchronously on card_ref_clock
// [RULE10] Separate card inserted and removed interrupts
// [RULE11] Separate powered up and down interrupts
// [RULE12] Interrupt on character transmission error
// [RULE13] Answer start and duration timeout interrupts
// [RULE14] Block gap and character gap timeout interrupts
// [RULE15] Interrupt when receive FIFO read times out
// [RULE16] Interrupt when receive level reaches threshold
// [RULE17] Interrupt when transmit level reaches threshold
// [RULE18] Combined interrupt ORs twelve masked sources
// [RULE19] Write on enable edge, read data zero-wait
module sci_apb_port #(
   parameter int LEVEL_W = 16
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic card_ref_clock,
   input wire logic ref_domain_reset_n,
   sci_apb_if.device bus,
   input wire logic [11:0] event_pulse,
   input wire logic [LEVEL_W-1:0] rx_level,
   input wire logic [LEVEL_W-1:0] tx_level,
   output logic [11:0] rx_thresh_hit_dummy_unused,
   output logic card_inserted_irq,
   output logic card_removed_irq,
   output logic card_powered_up_irq,
   output logic card_powered_down_irq,
   output logic tx_char_error_irq,
   output logic answer_start_timeout_irq,
   output logic answer_duration_timeout_irq,
   output logic block_gap_timeout_irq,
   output logic char_gap_timeout_irq,
   output logic rx_read_timeout_irq,
   output logic rx_level_irq,
   output logic tx_level_irq,
   output logic combined_irq
);
   // ****************************************************************
   // Reference domain: card events are toggled across
   // ****************************************************************
   logic [11:0] ref_tog_q;
   logic [11:0] ref_tog_d;
   always_comb begin
      ref_tog_d = ref_tog_q ^ event_pulse; // [RULE8]
   end
   always_ff @(posedge card_ref_clock) begin
      if (!ref_domain_reset_n) begin // [RULE9]
         ref_tog_q <= '0;
      end else begin
         ref_tog_q <= ref_tog_d;
      end
   end
   logic [11:0] tog_sync;
   sci_sync2 #(.W(12)) u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .async_in(ref_tog_q),
      .sync_out(tog_sync)
   );
   // ****************************************************************
   // Bus domain registers
   // ****************************************************************
   logic [11:0] tog_seen_q, tog_seen_d;
   logic [11:0] raw_q, raw_d;
   logic [11:0] mask_q, mask_d;
   logic [15:0] rx_th_q, rx_th_d;
   logic [15:0] tx_th_q, tx_th_d;
   logic [15:0] rdata_q, rdata_d;
   logic [11:0] irq_q, irq_d;
   logic comb_q, comb_d;
   logic [11:0] set_v;
   logic wr_en;
   logic rd_en;
   function automatic logic [11:0] pad12(input logic [15:0] v);
      pad12 = v[11:0];
   endfunction : pad12
   always_comb begin
      wr_en = bus.psel && bus.penable && bus.pwrite; // [RULE5] [RULE6] [RULE19]
      rd_en = bus.psel && !bus.penable && !bus.pwrite; // [RULE5] [RULE6] [RULE19]
      set_v = tog_sync ^ tog_seen_q;
      set_v[sci_edge_pkg::IRQ_RX_LEVEL] = (16'(rx_level) >= rx_th_q); // [RULE16]
      set_v[sci_edge_pkg::IRQ_TX_LEVEL] = (16'(tx_level) <= tx_th_q); // [RULE17]
      tog_seen_d = tog_sync;
      raw_d = raw_q;
      mask_d = mask_q;
      rx_th_d = rx_th_q;
      tx_th_d = tx_th_q;
      if (wr_en) begin
         case (bus.paddr) // [RULE1]
            sci_edge_pkg::OFF_MASK: mask_d = pad12(bus.pwdata); // [RULE7]
            sci_edge_pkg::OFF_CLEAR: raw_d = raw_q & ~pad12(bus.pwdata);
            sci_edge_pkg::OFF_RX_THRESH: rx_th_d = bus.pwdata;
            sci_edge_pkg::OFF_TX_THRESH: tx_th_d = bus.pwdata;
            default: raw_d = raw_d;
         endcase
      end
      raw_d = raw_d | set_v; // Set wins over clear
      rdata_d = 16'h0000;
      if (rd_en) begin
         case (bus.paddr) // [RULE1]
            sci_edge_pkg::OFF_MASK: rdata_d = {4'h0, mask_q};
            sci_edge_pkg::OFF_RAW: rdata_d = {4'h0, raw_q};
            sci_edge_pkg::OFF_STATUS: rdata_d = {4'h0, raw_q & mask_q};
            sci_edge_pkg::OFF_RX_THRESH: rdata_d = rx_th_q;
            sci_edge_pkg::OFF_TX_THRESH: rdata_d = tx_th_q;
            default: rdata_d = 16'h0000;
         endcase
      end
      irq_d = raw_q & mask_q; // [RULE10] [RULE11] [RULE12] [RULE13] [RULE14] [RULE15]
      comb_d = |(raw_q & mask_q); // [RULE18]
   end
   always_ff @(posedge ref_clk) begin // [RULE3]
      if (!resetn) begin // [RULE2]
         tog_seen_q <= '0;
         raw_q <= '0;
         mask_q <= sci_edge_pkg::MASK_RESET;
         rx_th_q <= sci_edge_pkg::THRESH_RESET;
         tx_th_q <= sci_edge_pkg::THRESH_RESET;
         rdata_q <= 16'h0000;
         irq_q <= '0;
         comb_q <= 1'b0;
      end else begin
         tog_seen_q <= tog_seen_d;
         raw_q <= raw_d;
         mask_q <= mask_d;
         rx_th_q <= rx_th_d;
         tx_th_q <= tx_th_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         comb_q <= comb_d;
      end
   end
   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign bus.prdata = rdata_q; // [RULE7] [RULE19]
   assign rx_thresh_hit_dummy_unused = raw_q;
   assign card_inserted_irq = irq_q[sci_edge_pkg::IRQ_CARD_IN];
   assign card_removed_irq = irq_q[sci_edge_pkg::IRQ_CARD_OUT];
   assign card_powered_up_irq = irq_q[sci_edge_pkg::IRQ_CARD_UP];
   assign card_powered_down_irq = irq_q[sci_edge_pkg::IRQ_CARD_DN];
   assign tx_char_error_irq = irq_q[sci_edge_pkg::IRQ_TX_ERR];
   assign answer_start_timeout_irq = irq_q[sci_edge_pkg::IRQ_ANS_START];
   assign answer_duration_timeout_irq = irq_q[sci_edge_pkg::IRQ_ANS_DUR];
   assign block_gap_timeout_irq = irq_q[sci_edge_pkg::IRQ_BLK_GAP];
   assign char_gap_timeout_irq = irq_q[sci_edge_pkg::IRQ_CHAR_GAP];
   assign rx_read_timeout_irq = irq_q[sci_edge_pkg::IRQ_RX_READ];
   assign rx_level_irq = irq_q[sci_edge_pkg::IRQ_RX_LEVEL];
   assign tx_level_irq = irq_q[sci_edge_pkg::IRQ_TX_LEVEL];
   assign combined_irq = comb_q;
endmodule : sci_apb_port
`default_nettype wire

/* File: design/sci_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sci_sync2 #(
   parameter int W = 12
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   // ****************************************************************
   // Two-stage synchroniser
   // ****************************************************************
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign sync_out = sync_q;
endmodule : sci_sync2
`default_nettype wire

/* File: include/sci_apb_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sci_apb_if;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:2] paddr;
   logic [15:0] pwdata;
   logic [15:0] prdata;
   modport device (input psel, input penable, input pwrite, input paddr, input pwdata, output prdata);
   modport bridge (output psel, output penable, output pwrite, output paddr, output pwdata, input prdata);
endinterface : sci_apb_if
`default_nettype wire

/* File: include/sci_edge_pkg.sv */
package sci_edge_pkg;
   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int ADDR_W = 6;
   localparam int DATA_W = 16;
   localparam int IRQ_N = 12;
   // ****************************************************************
   // Interrupt bit positions
   // ****************************************************************
   localparam int IRQ_CARD_IN = 0;
   localparam int IRQ_CARD_OUT = 1;
   localparam int IRQ_CARD_UP = 2;
   localparam int IRQ_CARD_DN = 3;
   localparam int IRQ_TX_ERR = 4;
   localparam int IRQ_ANS_START = 5;
   localparam int IRQ_ANS_DUR = 6;
   localparam int IRQ_BLK_GAP = 7;
   localparam int IRQ_CHAR_GAP = 8;
   localparam int IRQ_RX_READ = 9;
   localparam int IRQ_RX_LEVEL = 10;
   localparam int IRQ_TX_LEVEL = 11;
   // ****************************************************************
   // Register word offsets (index on address bits 7:2)
   // ****************************************************************
   localparam logic [5:0] OFF_MASK = 6'h00;
   localparam logic [5:0] OFF_RAW = 6'h01;
   localparam logic [5:0] OFF_STATUS = 6'h02;
   localparam logic [5:0] OFF_CLEAR = 6'h03;
   localparam logic [5:0] OFF_RX_THRESH = 6'h04;
   localparam logic [5:0] OFF_TX_THRESH = 6'h05;
   localparam logic [11:0] MASK_RESET = 12'h000;
   localparam logic [15:0] THRESH_RESET = 16'h0008;
endpackage : sci_edge_pkg

/* File: sim/sci_apb_port_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module sci_apb_port_checker (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:2] paddr,
   input wire logic [15:0] pwdata,
   input wire logic [15:0] prdata
);
   // ****************************************************************
   // Threshold shadow and bus checks
   // ****************************************************************
   logic [15:0] thr_q;
   logic [15:0] thr_d;
   logic rd;
   logic wr;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   assign rd = psel && penable && !pwrite;
   assign wr = psel && penable && pwrite;
   always_comb begin
      thr_d = thr_q;
      if (wr && paddr == sci_edge_pkg::OFF_RX_THRESH) begin
         thr_d = pwdata;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         thr_q <= sci_edge_pkg::THRESH_RESET;
      end else begin
         thr_q <= thr_d;
      end
   end
   a_enable_one_cycle: assert property (penable |=> !penable) else $error("enable held");
   a_setup_first: assert property ($rose(penable) |-> psel && $past(psel)) else $error("no setup");
   a_setup_to_enable: assert property (psel && !penable |=> psel && penable) else $error("no enable");
   a_ctrl_stable: assert property (penable |-> $stable(pwrite) && $stable(paddr) && $stable(pwdata))
      else $error("control moved");
   a_end_release: assert property (psel && penable |=> !psel) else $error("select held");
   a_rdata_idle: assert property (!rd |-> prdata == 16'h0000) else $error("stray read data");
   a_unmapped_zero: assert property (rd && paddr > sci_edge_pkg::OFF_TX_THRESH |-> prdata == 16'h0000)
      else $error("unmapped data");
   a_thresh_read: assert property (rd && paddr == sci_edge_pkg::OFF_RX_THRESH |-> prdata == thr_q)
      else $error("threshold mismatch");
   a_mask_width: assert property (rd && paddr == sci_edge_pkg::OFF_MASK |-> prdata[15:12] == 4'h0)
      else $error("mask too wide");
   c_read: cover property (rd);
   c_write: cover property (wr);
   c_thresh_write: cover property (wr && paddr == sci_edge_pkg::OFF_RX_THRESH);
endmodule : sci_apb_port_checker
`default_nettype wire

/* File: sim/tb_smart_card_if_apb_port_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_smart_card_if_apb_port_irq;
   // ****************************************************************
   // Bench
   // ****************************************************************
   logic ref_clk = 1'b0;
   logic card_ref_clock = 1'b0;
   logic resetn, ref_domain_reset_n, req_valid, req_write, req_ready, rsp_valid;
   logic [5:0] req_addr;
   logic [15:0] req_wdata, rsp_rdata, rx_level, tx_level, rd;
   logic [11:0] event_pulse, raw_obs;
   wire logic [11:0] irq_vec;
   wire logic combined_irq;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   sci_apb_if bus_if ();
   sci_apb_port sci_apb_port_i (.ref_clk(ref_clk), .resetn(resetn), .card_ref_clock(card_ref_clock),
      .ref_domain_reset_n(ref_domain_reset_n), .bus(bus_if), .event_pulse(event_pulse), .rx_level(rx_level),
      .tx_level(tx_level), .rx_thresh_hit_dummy_unused(raw_obs), .card_inserted_irq(irq_vec[0]),
      .card_removed_irq(irq_vec[1]), .card_powered_up_irq(irq_vec[2]), .card_powered_down_irq(irq_vec[3]),
      .tx_char_error_irq(irq_vec[4]), .answer_start_timeout_irq(irq_vec[5]),
      .answer_duration_timeout_irq(irq_vec[6]), .block_gap_timeout_irq(irq_vec[7]),
      .char_gap_timeout_irq(irq_vec[8]), .rx_read_timeout_irq(irq_vec[9]), .rx_level_irq(irq_vec[10]),
      .tx_level_irq(irq_vec[11]), .combined_irq(combined_irq));
   sci_apb_bridge sci_apb_bridge_i (.ref_clk(ref_clk), .resetn(resetn), .bus(bus_if), .req_valid(req_valid),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
   sci_apb_port_checker sci_apb_port_checker_i (.ref_clk(ref_clk), .resetn(resetn), .psel(bus_if.psel),
      .penable(bus_if.penable), .pwrite(bus_if.pwrite), .paddr(bus_if.paddr), .pwdata(bus_if.pwdata),
      .prdata(bus_if.prdata));
   always #4 ref_clk = ~ref_clk;
   always #5 card_ref_clock = ~card_ref_clock;
   task automatic close_out();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         close_out();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(negedge ref_clk);
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(posedge ref_clk);
      req_valid <= 1'b0;
      @(negedge ref_clk);
      while (rsp_valid !== 1'b1 && n < 100) begin
         @(negedge ref_clk);
         n++;
      end
      r = rsp_rdata;
      check("response", {15'h0000, rsp_valid}, 16'h0001);
   endtask : xfer
   task automatic pulse_wait(input int i, input int lim);
      int n;
      n = 0;
      @(posedge card_ref_clock);
      event_pulse <= 12'h001 << i;
      @(posedge card_ref_clock);
      event_pulse <= 12'h000;
      while (irq_vec === 12'h000 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
   endtask : pulse_wait
   task automatic t_regs();
      xfer(1'b0, sci_edge_pkg::OFF_MASK, 16'h0000, rd);
      check("mask reset", rd, 16'h0000);
      xfer(1'b0, sci_edge_pkg::OFF_TX_THRESH, 16'h0000, rd);
      check("tx thr", rd, 16'h0008);
      xfer(1'b1, sci_edge_pkg::OFF_MASK, 16'hFFFF, rd);
      xfer(1'b0, sci_edge_pkg::OFF_MASK, 16'h0000, rd);
      check("mask", rd, 16'h0FFF);
      xfer(1'b1, sci_edge_pkg::OFF_RX_THRESH, 16'h0003, rd);
      xfer(1'b0, sci_edge_pkg::OFF_RX_THRESH, 16'h0000, rd);
      check("rx thr", rd, 16'h0003);
      xfer(1'b1, 6'h3F, 16'hA5A5, rd);
      xfer(1'b0, 6'h3F, 16'h0000, rd);
      check("unmapped", rd, 16'h0000);
   endtask : t_regs
   task automatic t_events();
      for (int i = 0; i < 10; i++) begin
         pulse_wait(i, 30);
         check("irq", {4'h0, irq_vec}, 16'h0001 << i);
         check("combined", {15'h0000, combined_irq}, 16'h0001);
         xfer(1'b1, sci_edge_pkg::OFF_CLEAR, 16'h0001 << i, rd);
         repeat (2) @(negedge ref_clk);
         check("cleared", {4'h0, irq_vec}, 16'h0000);
      end
   endtask : t_events
   task automatic t_masked();
      xfer(1'b1, sci_edge_pkg::OFF_MASK, 16'h0000, rd);
      pulse_wait(4, 30);
      check("masked", {3'h0, combined_irq, irq_vec}, 16'h0000);
      check("raw out", {4'h0, raw_obs}, 16'h0010);
      xfer(1'b0, sci_edge_pkg::OFF_RAW, 16'h0000, rd);
      check("raw", rd, 16'h0010);
      xfer(1'b0, sci_edge_pkg::OFF_STATUS, 16'h0000, rd);
      check("status", rd, 16'h0000);
      xfer(1'b1, sci_edge_pkg::OFF_CLEAR, 16'h0FFF, rd);
      xfer(1'b1, sci_edge_pkg::OFF_MASK, 16'h0FFF, rd);
   endtask : t_masked
   task automatic t_level();
      @(posedge ref_clk);
      rx_level <= 16'h0003;
      repeat (6) @(negedge ref_clk);
      check("rx level", {4'h0, irq_vec}, 16'h0400);
      @(posedge ref_clk);
      tx_level <= 16'h0008;
      repeat (6) @(negedge ref_clk);
      check("tx level", {3'h0, combined_irq, irq_vec}, 16'h1C00);
   endtask : t_level
   initial begin
      resetn = 1'b0;
      ref_domain_reset_n = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 6'h00;
      req_wdata = 16'h0000;
      rx_level = 16'h0000;
      tx_level = 16'hFFFF;
      event_pulse = 12'h000;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge card_ref_clock);
      ref_domain_reset_n <= 1'b1;
      t_regs();
      t_events();
      t_masked();
      t_level();
      close_out();
   end
endmodule : tb_smart_card_if_apb_port_irq
`default_nettype wire
